// ---- src/sdram_bank_command_fsm.sv ----
`timescale 1ns/10ps
`include "sdram_bank_consts.svh"
module sdram_bank_command_fsm #(
    parameter int NUM_BANKS = 4,
    parameter int BURST_LEN = `BURST_LEN_DEFAULT,
    parameter int CAS_LAT = `CAS_LAT_DEFAULT
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // command pins
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [$clog2(NUM_BANKS)-1:0] ba,
    input wire logic a10,
    // state and verdicts
    output sdram_bank_pkg::bank_state_t bank_state [NUM_BANKS],
    output sdram_bank_pkg::dev_state_t dev_state,
    output logic cmd_accepted,
    output logic cmd_illegal,
    output logic burst_cut,
    output logic rd_takeover,
    output logic [$clog2(NUM_BANKS)-1:0] rd_owner
);

    localparam int BW = $clog2(NUM_BANKS);
    localparam int RP_CYC = `PRECHARGE_CYC;
    localparam int RCD_CYC = `ACT_COL_CYC;
    localparam int RFC_CYC = `REFRESH_CYC;
    localparam int MRD_CYC = `MODE_REG_CYC;
    localparam logic [7:0] RP_CNT = 8'(`PRECHARGE_CYC);
    localparam logic [7:0] RCD_CNT = 8'(`ACT_COL_CYC);
    localparam logic [7:0] BL_CNT = 8'(BURST_LEN);
    localparam logic [7:0] BLRP_CNT = 8'(BURST_LEN + `PRECHARGE_CYC);

    function automatic sdram_bank_pkg::cmd_t decode(
        input logic cs, input logic ras, input logic cas, input logic we);
        sdram_bank_pkg::cmd_t c;
        c = sdram_bank_pkg::CMD_DESEL;
        if (!cs) begin
            unique case ({ras, cas, we})
                3'h7: c = sdram_bank_pkg::CMD_NOP;
                3'h3: c = sdram_bank_pkg::CMD_ACT;
                3'h5: c = sdram_bank_pkg::CMD_RD;
                3'h4: c = sdram_bank_pkg::CMD_WR;
                3'h6: c = sdram_bank_pkg::CMD_BST;
                3'h2: c = sdram_bank_pkg::CMD_PRE;
                3'h1: c = sdram_bank_pkg::CMD_REF;
                3'h0: c = sdram_bank_pkg::CMD_LMR;
            endcase
        end
        return c;
    endfunction

    function automatic logic is_burst(input sdram_bank_pkg::bank_state_t s);
        return s == sdram_bank_pkg::BK_READ || s == sdram_bank_pkg::BK_WRITE;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // clock-enable gating

    logic cke_prev;
    logic [7:0] xsr_cnt;
    logic run;

    // any low-to-high step of clock-enable is treated as a self refresh
    // exit, costing a few idle cycles after a plain power-down too
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cke_prev <= 1'b0;
            xsr_cnt <= 8'h00;
        end else begin
            cke_prev <= cke;
            if (!cke_prev && cke) begin
                xsr_cnt <= 8'(`SR_EXIT_CYC);
            end else if (xsr_cnt != 8'h00) begin
                xsr_cnt <= xsr_cnt - 8'h01;
            end
        end
    end

    assign run = cke_prev && cke && xsr_cnt == 8'h00;

    ////////////////////////////////////////////////////////////////////
    // command legality

    sdram_bank_pkg::cmd_t cmd;
    sdram_bank_pkg::bank_state_t tgt;
    logic norm;
    logic all_idle;
    logic pre_all_ok;
    logic legal;
    logic exec;
    logic [BW-1:0] last_bank;
    logic last_valid;
    logic [7:0] cnt [NUM_BANKS];

    assign cmd = run ? decode(cs_n, ras_n, cas_n, we_n) : sdram_bank_pkg::CMD_DESEL;
    assign tgt = bank_state[ba];
    assign norm = dev_state == sdram_bank_pkg::DEV_NORMAL;

    always_comb begin
        all_idle = 1'b1;
        pre_all_ok = 1'b1;
        for (int i = 0; i < NUM_BANKS; i++) begin
            if (bank_state[i] != sdram_bank_pkg::BK_IDLE) begin
                all_idle = 1'b0;
            end
            if (!(bank_state[i] inside {sdram_bank_pkg::BK_IDLE,
                    sdram_bank_pkg::BK_ACTIVE, sdram_bank_pkg::BK_READ,
                    sdram_bank_pkg::BK_WRITE})) begin
                pre_all_ok = 1'b0;
            end
        end
    end

    // for activate, read, write and single precharge only the target bank's state matters,
    // so busy neighbours never block those; refresh, mode load and precharge-all check every bank
    always_comb begin
        legal = 1'b0;
        unique case (cmd)
            sdram_bank_pkg::CMD_DESEL,
            sdram_bank_pkg::CMD_NOP: legal = 1'b1;
            sdram_bank_pkg::CMD_ACT:
                legal = norm && tgt == sdram_bank_pkg::BK_IDLE;
            sdram_bank_pkg::CMD_RD,
            sdram_bank_pkg::CMD_WR:
                legal = norm && (tgt == sdram_bank_pkg::BK_ACTIVE || is_burst(tgt));
            sdram_bank_pkg::CMD_PRE:
                legal = norm && (a10 ? pre_all_ok :
                    (tgt == sdram_bank_pkg::BK_IDLE || tgt == sdram_bank_pkg::BK_ACTIVE
                    || is_burst(tgt)));
            sdram_bank_pkg::CMD_BST:
                legal = norm && last_valid && is_burst(bank_state[last_bank]);
            sdram_bank_pkg::CMD_REF,
            sdram_bank_pkg::CMD_LMR: legal = norm && all_idle;
        endcase
    end

    assign exec = legal && cmd != sdram_bank_pkg::CMD_DESEL
        && cmd != sdram_bank_pkg::CMD_NOP;

    ////////////////////////////////////////////////////////////////////
    // latest burst for terminate

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            last_bank <= '0;
            last_valid <= 1'b0;
        end else if (exec && (cmd == sdram_bank_pkg::CMD_RD
                || cmd == sdram_bank_pkg::CMD_WR)) begin
            last_bank <= ba;
            last_valid <= 1'b1;
        end else if (exec && cmd == sdram_bank_pkg::CMD_BST) begin
            last_valid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // per-bank state and counter

    for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
        logic hit;
        logic rw;
        assign hit = ba == BW'(b);
        assign rw = cmd == sdram_bank_pkg::CMD_RD || cmd == sdram_bank_pkg::CMD_WR;

        always_ff @(posedge sys_clk) begin
            if (sys_rst) begin
                bank_state[b] <= sdram_bank_pkg::BK_IDLE;
                cnt[b] <= 8'h00;
            end else if (exec && cmd == sdram_bank_pkg::CMD_ACT && hit) begin
                bank_state[b] <= sdram_bank_pkg::BK_ACTIVATING;
                cnt[b] <= RCD_CNT;
            end else if (exec && rw && hit) begin
                if (a10) begin
                    bank_state[b] <= cmd == sdram_bank_pkg::CMD_RD ?
                        sdram_bank_pkg::BK_READ_AP : sdram_bank_pkg::BK_WRITE_AP;
                    cnt[b] <= BLRP_CNT;
                end else begin
                    bank_state[b] <= cmd == sdram_bank_pkg::CMD_RD ?
                        sdram_bank_pkg::BK_READ : sdram_bank_pkg::BK_WRITE;
                    cnt[b] <= BL_CNT;
                end
            end else if (exec && cmd == sdram_bank_pkg::CMD_PRE && (a10 || hit)
                    && bank_state[b] != sdram_bank_pkg::BK_IDLE) begin
                bank_state[b] <= sdram_bank_pkg::BK_PRECHARGING;
                cnt[b] <= RP_CNT;
            end else if (exec && rw && is_burst(bank_state[b])) begin
                // the other bank's burst takes the data bus
                bank_state[b] <= sdram_bank_pkg::BK_ACTIVE;
                cnt[b] <= 8'h00;
            end else if (exec && rw && cnt[b] > RP_CNT
                    && (bank_state[b] == sdram_bank_pkg::BK_READ_AP
                    || bank_state[b] == sdram_bank_pkg::BK_WRITE_AP)) begin
                cnt[b] <= RP_CNT;
            end else if (exec && cmd == sdram_bank_pkg::CMD_BST
                    && last_bank == BW'(b)) begin
                bank_state[b] <= sdram_bank_pkg::BK_ACTIVE;
                cnt[b] <= 8'h00;
            end else if (cnt[b] != 8'h00) begin
                cnt[b] <= cnt[b] - 8'h01;
                if (cnt[b] == 8'h01) begin
                    bank_state[b] <= (bank_state[b] == sdram_bank_pkg::BK_ACTIVATING
                        || is_burst(bank_state[b])) ?
                        sdram_bank_pkg::BK_ACTIVE : sdram_bank_pkg::BK_IDLE;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // device-wide state

    logic [7:0] dev_cnt;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            dev_state <= sdram_bank_pkg::DEV_NORMAL;
            dev_cnt <= 8'h00;
        end else if (exec && cmd == sdram_bank_pkg::CMD_REF) begin
            dev_state <= sdram_bank_pkg::DEV_REFRESH;
            dev_cnt <= 8'(`REFRESH_CYC);
        end else if (exec && cmd == sdram_bank_pkg::CMD_LMR) begin
            dev_state <= sdram_bank_pkg::DEV_MODE_REG;
            dev_cnt <= 8'(`MODE_REG_CYC);
        end else if (exec && cmd == sdram_bank_pkg::CMD_PRE && a10) begin
            dev_state <= sdram_bank_pkg::DEV_PRE_ALL;
            dev_cnt <= RP_CNT;
        end else if (dev_cnt != 8'h00) begin
            dev_cnt <= dev_cnt - 8'h01;
            if (dev_cnt == 8'h01) begin
                dev_state <= sdram_bank_pkg::DEV_NORMAL;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // verdicts

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cmd_accepted <= 1'b0;
            cmd_illegal <= 1'b0;
            burst_cut <= 1'b0;
        end else begin
            cmd_accepted <= exec;
            cmd_illegal <= !legal;
            burst_cut <= exec && (cmd == sdram_bank_pkg::CMD_BST
                || (cmd == sdram_bank_pkg::CMD_PRE && !a10 && is_burst(tgt)));
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read data bus ownership

    logic [CAS_LAT-1:0] pipe_v;
    logic [BW-1:0] pipe_b [CAS_LAT];

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pipe_v <= '0;
            for (int i = 0; i < CAS_LAT; i++) begin
                pipe_b[i] <= '0;
            end
        end else begin
            pipe_v[0] <= exec && cmd == sdram_bank_pkg::CMD_RD;
            pipe_b[0] <= ba;
            for (int i = 1; i < CAS_LAT; i++) begin
                pipe_v[i] <= pipe_v[i-1];
                pipe_b[i] <= pipe_b[i-1];
            end
        end
    end

    // the last pipeline stage is the output flop itself
    assign rd_takeover = pipe_v[CAS_LAT-1];
    assign rd_owner = pipe_b[CAS_LAT-1];

    ////////////////////////////////////////////////////////////////////
    // checks

    a_cke_gates: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !(cke_prev && cke) |=> !cmd_accepted)
        else $error("command accepted without clock-enable held");

    a_nop_keeps: assert property (@(posedge sys_clk) disable iff (sys_rst)
        cmd == sdram_bank_pkg::CMD_NOP && bank_state[0] == sdram_bank_pkg::BK_ACTIVE
        |=> bank_state[0] == sdram_bank_pkg::BK_ACTIVE)
        else $error("no-operation changed an open bank");

    a_pre_idle_nop: assert property (@(posedge sys_clk) disable iff (sys_rst)
        norm && cmd == sdram_bank_pkg::CMD_PRE && !a10 && tgt == sdram_bank_pkg::BK_IDLE
        |=> bank_state[$past(ba)] == sdram_bank_pkg::BK_IDLE && cmd_accepted)
        else $error("precharge to idle bank changed it");

    a_act_delay: assert property (@(posedge sys_clk) disable iff (sys_rst)
        exec && cmd == sdram_bank_pkg::CMD_ACT && ba == '0
        |=> bank_state[0] == sdram_bank_pkg::BK_ACTIVATING
        ##RCD_CYC bank_state[0] == sdram_bank_pkg::BK_ACTIVE)
        else $error("activate delay wrong");

    a_refresh_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
        exec && cmd == sdram_bank_pkg::CMD_REF
        |=> dev_state == sdram_bank_pkg::DEV_REFRESH
        ##RFC_CYC dev_state == sdram_bank_pkg::DEV_NORMAL)
        else $error("refresh hold time wrong");

    a_mode_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
        exec && cmd == sdram_bank_pkg::CMD_LMR
        |=> dev_state == sdram_bank_pkg::DEV_MODE_REG
        ##MRD_CYC dev_state == sdram_bank_pkg::DEV_NORMAL)
        else $error("mode register hold time wrong");

    a_pre_all_idle: assert property (@(posedge sys_clk) disable iff (sys_rst)
        exec && cmd == sdram_bank_pkg::CMD_PRE && a10
        |=> dev_state == sdram_bank_pkg::DEV_PRE_ALL ##RP_CYC all_idle && norm)
        else $error("precharge all did not end idle");

    a_bst_stops: assert property (@(posedge sys_clk) disable iff (sys_rst)
        exec && cmd == sdram_bank_pkg::CMD_BST
        |=> bank_state[$past(last_bank)] == sdram_bank_pkg::BK_ACTIVE && burst_cut)
        else $error("burst terminate missed latest burst");

    a_ap_interrupt: assert property (@(posedge sys_clk) disable iff (sys_rst)
        exec && cmd == sdram_bank_pkg::CMD_RD && ba != BW'(1) && cnt[1] > RP_CNT
        && bank_state[1] == sdram_bank_pkg::BK_READ_AP |=> cnt[1] == RP_CNT)
        else $error("interrupted autoprecharge did not start precharge");

    a_rd_takeover: assert property (@(posedge sys_clk) disable iff (sys_rst)
        exec && cmd == sdram_bank_pkg::CMD_RD
        |-> ##CAS_LAT rd_takeover && rd_owner == $past(ba, CAS_LAT))
        else $error("read bus takeover latency wrong");

    c_refresh: cover property (@(posedge sys_clk) disable iff (sys_rst)
        exec && cmd == sdram_bank_pkg::CMD_REF);
    c_bst: cover property (@(posedge sys_clk) disable iff (sys_rst)
        exec && cmd == sdram_bank_pkg::CMD_BST);
    c_ap_cut: cover property (@(posedge sys_clk) disable iff (sys_rst)
        exec && cmd == sdram_bank_pkg::CMD_WR && ba != '0
        && bank_state[0] == sdram_bank_pkg::BK_READ_AP);

endmodule

// ---- src/sdram_bank_consts.svh ----
`ifndef SDRAM_BANK_CONSTS_SVH
`define SDRAM_BANK_CONSTS_SVH

`define CLK_PERIOD_NS 40

// times in ns; least times, so counts round up
`define PRECHARGE_PERIOD_NS 20
`define ACTIVATE_TO_COLUMN_DELAY_NS 20
`define REFRESH_CYCLE_TIME_NS 70
`define MODE_REGISTER_DELAY_NS 80
`define SELF_REFRESH_EXIT_TIME_NS 80

`define CYC(t) (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PRECHARGE_CYC `CYC(`PRECHARGE_PERIOD_NS)
`define ACT_COL_CYC `CYC(`ACTIVATE_TO_COLUMN_DELAY_NS)
`define REFRESH_CYC `CYC(`REFRESH_CYCLE_TIME_NS)
`define MODE_REG_CYC `CYC(`MODE_REGISTER_DELAY_NS)
`define SR_EXIT_CYC `CYC(`SELF_REFRESH_EXIT_TIME_NS)

`define BURST_LEN_DEFAULT 4
`define CAS_LAT_DEFAULT 3

`endif

// ---- src/sdram_bank_pkg.sv ----
package sdram_bank_pkg;

    typedef enum logic [3:0] {
        CMD_DESEL = 4'h0,
        CMD_NOP = 4'h1,
        CMD_ACT = 4'h2,
        CMD_RD = 4'h3,
        CMD_WR = 4'h4,
        CMD_BST = 4'h5,
        CMD_PRE = 4'h6,
        CMD_REF = 4'h7,
        CMD_LMR = 4'h8
    } cmd_t;

    typedef enum logic [2:0] {
        BK_IDLE = 3'h0,
        BK_ACTIVATING = 3'h1,
        BK_ACTIVE = 3'h2,
        BK_READ = 3'h3,
        BK_WRITE = 3'h4,
        BK_READ_AP = 3'h5,
        BK_WRITE_AP = 3'h6,
        BK_PRECHARGING = 3'h7
    } bank_state_t;

    typedef enum logic [1:0] {
        DEV_NORMAL = 2'h0,
        DEV_REFRESH = 2'h1,
        DEV_MODE_REG = 2'h2,
        DEV_PRE_ALL = 2'h3
    } dev_state_t;

endpackage

// ---- test/sdram_bank_command_fsm_tb_top.sv ----
`timescale 1ns/10ps
module sdram_bank_command_fsm_tb_top;
    typedef struct packed {
        logic ill;
        logic cut;
        logic [1:0] bk;
        logic [2:0] st;
        logic [1:0] dv;
    } note_t;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic cke, cs_n, ras_n, cas_n, we_n, a10;
    logic [1:0] ba;
    logic [1:0] rd_owner;
    logic [1:0] rb;
    sdram_bank_pkg::bank_state_t bank_state [4];
    sdram_bank_pkg::dev_state_t dev_state;
    logic cmd_accepted, cmd_illegal, burst_cut, rd_takeover;
    note_t notes [$];
    note_t got;
    int n_mismatch = 0;
    int tests_run = 0;

    always #20 sys_clk = ~sys_clk;

    sdram_bank_command_fsm #(.NUM_BANKS(4), .BURST_LEN(4), .CAS_LAT(3))
    sdram_bank_command_fsm_inst (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
        .cas_n(cas_n), .we_n(we_n), .ba(ba), .a10(a10), .bank_state(bank_state),
        .dev_state(dev_state), .cmd_accepted(cmd_accepted), .cmd_illegal(cmd_illegal),
        .burst_cut(burst_cut), .rd_takeover(rd_takeover), .rd_owner(rd_owner)
    );

    sdram_ctrl_model sdram_ctrl_model_inst (
        .sys_clk(sys_clk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
        .we_n(we_n), .ba(ba), .a10(a10)
    );

    ////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("compared %0d, wrong %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // note the answer first, then put the command on the pins
    task automatic cmd(input sdram_bank_pkg::cmd_t c, input logic [1:0] b, input logic ap,
                       input logic ill, input logic [1:0] cb, input logic [2:0] st,
                       input logic cut, input logic [1:0] dv);
        notes.push_back({ill, cut, cb, st, dv});
        sdram_ctrl_model_inst.drive(c, b, ap);
    endtask

    task automatic ok(input sdram_bank_pkg::cmd_t c, input logic [1:0] b, input logic ap,
                      input logic [2:0] st);
        cmd(c, b, ap, 1'b0, b, st, 1'b0, 2'h0);
    endtask

    task automatic idle(input int k);
        sdram_ctrl_model_inst.idle(k);
    endtask

    // every verdict pulse consumes the oldest note
    always @(negedge sys_clk) begin
        if (cmd_accepted === 1'b1 || cmd_illegal === 1'b1) begin
            if (notes.size() == 0) begin
                check(8'h1, 8'h0);
            end else begin
                got = notes.pop_front();
                check(cmd_illegal, got.ill);
                check(bank_state[got.bk], got.st);
                check(dev_state, got.dv);
                check(burst_cut, got.cut);
            end
        end
    end

    initial begin
        #400000;
        n_mismatch++;
        results();
    end

    ////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(negedge sys_clk);
        sys_rst = 1'b0;
        idle(6);
        for (int i = 0; i < 4; i++) check(bank_state[i], 3'h0);
        check(dev_state, 2'h0);
        check(rd_takeover, 1'b0);
        $display("reset state done");

        ok(sdram_bank_pkg::CMD_ACT, 2'h0, 1'b0, 3'h1);
        idle(1);
        check(bank_state[0], 3'h2);
        ok(sdram_bank_pkg::CMD_RD, 2'h0, 1'b0, 3'h3);
        ok(sdram_bank_pkg::CMD_RD, 2'h0, 1'b0, 3'h3);
        ok(sdram_bank_pkg::CMD_WR, 2'h0, 1'b0, 3'h4);
        ok(sdram_bank_pkg::CMD_RD, 2'h0, 1'b0, 3'h3);
        ok(sdram_bank_pkg::CMD_WR, 2'h0, 1'b0, 3'h4);
        ok(sdram_bank_pkg::CMD_WR, 2'h0, 1'b0, 3'h4);
        cmd(sdram_bank_pkg::CMD_BST, 2'h3, 1'b0, 1'b0, 2'h0, 3'h2, 1'b1, 2'h0);
        ok(sdram_bank_pkg::CMD_RD, 2'h0, 1'b0, 3'h3);
        cmd(sdram_bank_pkg::CMD_PRE, 2'h0, 1'b0, 1'b0, 2'h0, 3'h7, 1'b1, 2'h0);
        idle(1);
        check(bank_state[0], 3'h0);
        ok(sdram_bank_pkg::CMD_ACT, 2'h0, 1'b0, 3'h1);
        idle(1);
        ok(sdram_bank_pkg::CMD_WR, 2'h0, 1'b0, 3'h4);
        cmd(sdram_bank_pkg::CMD_PRE, 2'h0, 1'b0, 1'b0, 2'h0, 3'h7, 1'b1, 2'h0);
        idle(1);
        $display("single bank done");

        ok(sdram_bank_pkg::CMD_ACT, 2'h1, 1'b0, 3'h1);
        ok(sdram_bank_pkg::CMD_ACT, 2'h2, 1'b0, 3'h1);
        idle(1);
        ok(sdram_bank_pkg::CMD_RD, 2'h1, 1'b1, 3'h5);
        ok(sdram_bank_pkg::CMD_RD, 2'h2, 1'b0, 3'h3);
        idle(1);
        check(bank_state[1], 3'h0);
        idle(1);
        check(rd_takeover, 1'b1);
        check(rd_owner, 2'h2);
        cmd(sdram_bank_pkg::CMD_BST, 2'h0, 1'b0, 1'b0, 2'h2, 3'h2, 1'b1, 2'h0);
        ok(sdram_bank_pkg::CMD_PRE, 2'h1, 1'b0, 3'h0);
        cmd(sdram_bank_pkg::CMD_PRE, 2'h0, 1'b1, 1'b0, 2'h2, 3'h7, 1'b0, 2'h3);
        idle(1);
        check(dev_state, 2'h0);
        check(bank_state[2], 3'h0);
        $display("cross bank done");

        cmd(sdram_bank_pkg::CMD_REF, 2'h0, 1'b0, 1'b0, 2'h0, 3'h0, 1'b0, 2'h1);
        cmd(sdram_bank_pkg::CMD_ACT, 2'h0, 1'b0, 1'b1, 2'h0, 3'h0, 1'b0, 2'h1);
        idle(1);
        check(dev_state, 2'h0);
        cmd(sdram_bank_pkg::CMD_LMR, 2'h0, 1'b0, 1'b0, 2'h0, 3'h0, 1'b0, 2'h2);
        idle(1);
        check(dev_state, 2'h2);
        idle(1);
        check(dev_state, 2'h0);
        $display("device wide done");

        ok(sdram_bank_pkg::CMD_ACT, 2'h3, 1'b0, 3'h1);
        idle(1);
        cmd(sdram_bank_pkg::CMD_REF, 2'h0, 1'b0, 1'b1, 2'h3, 3'h2, 1'b0, 2'h0);
        cmd(sdram_bank_pkg::CMD_RD, 2'h1, 1'b0, 1'b1, 2'h1, 3'h0, 1'b0, 2'h0);
        cmd(sdram_bank_pkg::CMD_BST, 2'h3, 1'b0, 1'b1, 2'h3, 3'h2, 1'b0, 2'h0);
        ok(sdram_bank_pkg::CMD_WR, 2'h3, 1'b1, 3'h6);
        idle(4);
        check(bank_state[3], 3'h6);
        idle(1);
        check(bank_state[3], 3'h0);
        $display("refusals done");

        // low clock-enable, then the rising edge itself: both ignored
        sdram_ctrl_model_inst.set_cke(1'b0);
        sdram_ctrl_model_inst.drive(sdram_bank_pkg::CMD_ACT, 2'h0, 1'b0);
        sdram_ctrl_model_inst.set_cke(1'b1);
        sdram_ctrl_model_inst.drive(sdram_bank_pkg::CMD_ACT, 2'h0, 1'b0);
        idle(2);
        check(bank_state[0], 3'h0);
        ok(sdram_bank_pkg::CMD_ACT, 2'h0, 1'b0, 3'h1);
        idle(1);
        ok(sdram_bank_pkg::CMD_PRE, 2'h0, 1'b0, 3'h7);
        idle(1);
        $display("clock enable done");

        repeat (8) begin
            sdram_ctrl_model_inst.pick(rb);
            ok(sdram_bank_pkg::CMD_ACT, rb, 1'b0, 3'h1);
            idle(1);
            ok(sdram_bank_pkg::CMD_PRE, rb, 1'b0, 3'h7);
            idle(1);
        end
        idle(2);
        check(8'(notes.size()), 8'h0);
        $display("random banks done");
        results();
    end
endmodule

// ---- test/sdram_ctrl_model.sv ----
`timescale 1ns/10ps
////////////////////////////////////////////////////////////
module sdram_ctrl_model (
    // clock
    input wire logic sys_clk,
    // command pins
    output logic cke,
    output logic cs_n,
    output logic ras_n,
    output logic cas_n,
    output logic we_n,
    output logic [1:0] ba,
    output logic a10
);
    integer seed = 32'hd708;

    initial begin
        cke = 1'b1;
        {cs_n, ras_n, cas_n, we_n, ba, a10} = 7'h7f;
    end

    ////////////////////////////////////////////////////////////
    // pins change only at the falling edge and hold a whole cycle
    task automatic drive(input sdram_bank_pkg::cmd_t c, input logic [1:0] b, input logic ap);
        logic [3:0] p;
        // a free cycle before each write leaves the data bus to the byte mask
        if (c == sdram_bank_pkg::CMD_WR) begin
            {cs_n, ras_n, cas_n, we_n} = 4'h7;
            @(negedge sys_clk);
        end
        case (c)
            sdram_bank_pkg::CMD_NOP: p = 4'h7;
            sdram_bank_pkg::CMD_ACT: p = 4'h3;
            sdram_bank_pkg::CMD_RD: p = 4'h5;
            sdram_bank_pkg::CMD_WR: p = 4'h4;
            sdram_bank_pkg::CMD_BST: p = 4'h6;
            sdram_bank_pkg::CMD_PRE: p = 4'h2;
            sdram_bank_pkg::CMD_REF: p = 4'h1;
            sdram_bank_pkg::CMD_LMR: p = 4'h0;
            default: p = 4'hf;
        endcase
        {cs_n, ras_n, cas_n, we_n} = p;
        ba = b;
        a10 = ap;
        @(negedge sys_clk);
    endtask

    // gaps: deselect or no-operation, the other pins scrambled so stale values never help
    task automatic idle(input int n);
        logic [31:0] r;
        repeat (n) begin
            r = $random(seed);
            if (!r[6]) r[5:3] = 3'h7;
            {cs_n, ras_n, cas_n, we_n, ba, a10} = r[6:0];
            @(negedge sys_clk);
        end
    endtask

    task automatic pick(output logic [1:0] b);
        logic [31:0] r;
        r = $random(seed);
        b = r[1:0];
    endtask

    task automatic set_cke(input logic v);
        cke = v;
    endtask
endmodule
